// File: core/motion_status_pkg.sv
`default_nettype none
package motion_status_pkg;

  // register offsets on the byte-wide register port
  localparam logic [7:0] ADDR_TIME_LOW = 8'h18;
  localparam logic [7:0] ADDR_TIME_MID = 8'h19;
  localparam logic [7:0] ADDR_TIME_HIGH = 8'h1A;
  localparam logic [7:0] ADDR_PWR_EVENT = 8'h1B;
  localparam logic [7:0] ADDR_FEAT_IRQ = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h1D;
  localparam logic [7:0] ADDR_STEP0 = 8'h1E;
  localparam logic [7:0] ADDR_STEP1 = 8'h1F;
  localparam logic [7:0] ADDR_STEP2 = 8'h20;
  localparam logic [7:0] ADDR_STEP3 = 8'h21;
  localparam logic [7:0] ADDR_TEMP = 8'h22;
  localparam logic [7:0] ADDR_LEVEL_LOW = 8'h24;
  localparam logic [7:0] ADDR_LEVEL_HIGH = 8'h25;
  localparam logic [7:0] ADDR_QUEUE_PORT = 8'h26;
  localparam logic [7:0] ADDR_MOTION_CLASS = 8'h27;
  localparam logic [7:0] ADDR_HEALTH = 8'h2A;

  // field positions
  localparam int PWR_FLAG_BIT = 0;
  localparam int IRQ_ACC_DRDY_BIT = 7;
  localparam int IRQ_AUX_DRDY_BIT = 5;
  localparam int IRQ_WTM_BIT = 1;
  localparam int IRQ_FULL_BIT = 0;
  localparam int HEALTH_REMAP_BIT = 5;
  localparam int HEALTH_LOW_RATE_BIT = 6;
  localparam int HEALTH_TAP_RATE_BIT = 7;
  localparam int MSG_W = 5;
  localparam int TIME_W = 24;
  localparam int LEVEL_W = 14;
  localparam int LEVEL_HIGH_W = 6;

  // reset values and fixed answers
  localparam logic [7:0] PWR_EVENT_RESET = 8'h01;
  localparam logic [7:0] IRQ_FLAGS_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [7:0] QUEUE_EMPTY_READ = 8'h00;

  // health message codes
  localparam logic [MSG_W-1:0] MSG_NOT_INIT = 5'h00;
  localparam logic [MSG_W-1:0] MSG_INIT_OK = 5'h01;
  localparam logic [MSG_W-1:0] MSG_INIT_ERR = 5'h02;
  localparam logic [MSG_W-1:0] MSG_DRV_ERR = 5'h03;
  localparam logic [MSG_W-1:0] MSG_SNS_STOP = 5'h04;

  // time base: one count of the low time byte in ps, system clock period in ps
  localparam logic [25:0] TIME_TICK_PS = 26'd39062500;
  localparam logic [25:0] CLK_PERIOD_PS = 26'd50000;

  // data-rate code of 50 Hz
  localparam logic [3:0] RATE_50HZ_CODE = 4'h7;

endpackage : motion_status_pkg
`default_nettype wire

// File: core/motion_sensor_status_regs.sv
`timescale 1ns/100ps
`default_nettype none

module motion_sensor_status_regs
  import motion_status_pkg::*;
#(
  parameter int DEPTH = 1024,
  parameter logic [3:0] TAP_MIN_RATE_CODE = 4'h9
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic soft_rst,
  // register port
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [7:0] reg_addr,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // sensor core events and readings
  input wire logic acc_drdy_evt,
  input wire logic aux_drdy_evt,
  input wire logic [7:0] temp_raw,
  input wire logic [LEVEL_W-1:0] wtm_level,
  // configuration checked for health
  input wire logic [MSG_W-1:0] init_msg,
  input wire logic [1:0] remap_src_x,
  input wire logic [1:0] remap_src_y,
  input wire logic [1:0] remap_src_z,
  input wire logic [3:0] acc_rate_code,
  input wire logic rate50_features_on,
  input wire logic tap_on,
  // queue byte stream from the sensor core
  input wire logic q_in_valid,
  input wire logic [7:0] q_in_data,
  output logic q_in_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [LEVEL_W-1:0] LEVEL_FULL = LEVEL_W'(DEPTH);

  typedef struct packed {
    logic [25:0] time_frac;
    logic [TIME_W-1:0] time_cnt;
    logic pwr_flag;
    logic irq_acc;
    logic irq_aux;
    logic irq_wtm;
    logic irq_full;
    logic [1:0][7:0] skid;
    logic [1:0] skid_cnt;
    logic in_ready;
    logic [DEPTH-1:0][7:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [LEVEL_W-1:0] level;
    logic remap_err;
    logic low_rate_feature_fault;
    logic tap_rate_err;
    logic [MSG_W-1:0] msg;
    logic [7:0] rdata;
    logic rvalid;
  } state_s;

  state_s s_reg;
  state_s s_next;

  logic rd_go;
  logic pop;
  logic drain;
  logic push;
  logic [LEVEL_W-1:0] lvl_new;
  logic [25:0] frac_sum;

  assign rd_go = rd_en && !wr_en;
  assign pop = rd_go && (reg_addr == ADDR_QUEUE_PORT) && (s_reg.level != '0);
  assign drain = (s_reg.skid_cnt != 2'd0) && (s_reg.level != LEVEL_FULL);
  assign push = q_in_valid && s_reg.in_ready;
  assign frac_sum = s_reg.time_frac + CLK_PERIOD_PS;

  always_comb begin
    lvl_new = s_reg.level;
    s_next = s_reg;
    s_next.rvalid = 1'b0;

    // fractional accumulator keeps the exact 39.0625 us step on a 50 ns clock
    if (frac_sum >= TIME_TICK_PS) begin
      s_next.time_frac = frac_sum - TIME_TICK_PS;
      s_next.time_cnt = s_reg.time_cnt + 1'b1;
    end else begin
      s_next.time_frac = frac_sum;
    end

    // two-entry skid buffer ahead of the queue memory
    if (drain) begin
      s_next.mem[s_reg.wptr] = s_reg.skid[0];
      s_next.wptr = s_reg.wptr + 1'b1;
      s_next.skid[0] = s_reg.skid[1];
    end
    if (push) begin
      s_next.skid[s_reg.skid_cnt - (drain ? 2'd1 : 2'd0)] = q_in_data;
    end
    s_next.skid_cnt = s_reg.skid_cnt + (push ? 2'd1 : 2'd0) - (drain ? 2'd1 : 2'd0);
    // ready stays registered; at most one cycle late, the second entry absorbs it
    s_next.in_ready = (s_next.skid_cnt != 2'd2);

    if (pop) begin
      s_next.rptr = s_reg.rptr + 1'b1;
    end
    lvl_new = s_reg.level + (drain ? LEVEL_W'(1) : LEVEL_W'(0)) - (pop ? LEVEL_W'(1) : LEVEL_W'(0));
    s_next.level = lvl_new;

    // health: registered so the read path sees stable values
    s_next.msg = init_msg;
    s_next.remap_err = (remap_src_x == remap_src_y) || (remap_src_x == remap_src_z) ||
                       (remap_src_y == remap_src_z) || (remap_src_x == 2'd3) ||
                       (remap_src_y == 2'd3) || (remap_src_z == 2'd3);
    s_next.low_rate_feature_fault = rate50_features_on && (acc_rate_code < RATE_50HZ_CODE);
    s_next.tap_rate_err = tap_on && (acc_rate_code < TAP_MIN_RATE_CODE);

    // register reads; writes fall through untouched
    if (rd_go) begin
      s_next.rvalid = 1'b1;
      case (reg_addr)
        ADDR_TIME_LOW: s_next.rdata = s_reg.time_cnt[7:0];
        ADDR_TIME_MID: s_next.rdata = s_reg.time_cnt[15:8];
        ADDR_TIME_HIGH: s_next.rdata = s_reg.time_cnt[23:16];
        ADDR_PWR_EVENT: begin
          s_next.rdata = READ_ZERO;
          s_next.rdata[PWR_FLAG_BIT] = s_reg.pwr_flag;
          s_next.pwr_flag = 1'b0;
        end
        ADDR_IRQ_FLAGS: begin
          s_next.rdata = IRQ_FLAGS_RESET;
          s_next.rdata[IRQ_ACC_DRDY_BIT] = s_reg.irq_acc;
          s_next.rdata[IRQ_AUX_DRDY_BIT] = s_reg.irq_aux;
          s_next.rdata[IRQ_WTM_BIT] = s_reg.irq_wtm;
          s_next.rdata[IRQ_FULL_BIT] = s_reg.irq_full;
          s_next.irq_acc = 1'b0;
          s_next.irq_aux = 1'b0;
          s_next.irq_wtm = 1'b0;
          s_next.irq_full = 1'b0;
        end
        ADDR_TEMP: s_next.rdata = temp_raw;
        ADDR_LEVEL_LOW: s_next.rdata = s_reg.level[7:0];
        ADDR_LEVEL_HIGH: s_next.rdata = {2'b00, s_reg.level[LEVEL_W-1:8]};
        ADDR_QUEUE_PORT: s_next.rdata = pop ? s_reg.mem[s_reg.rptr] : QUEUE_EMPTY_READ;
        ADDR_HEALTH: begin
          s_next.rdata = {s_reg.tap_rate_err, s_reg.low_rate_feature_fault, s_reg.remap_err, s_reg.msg};
        end
        // feature-engine registers read zero until that engine exists
        default: s_next.rdata = READ_ZERO;
      endcase
    end

    // events set after the clear, so a set in the clearing cycle wins
    if (acc_drdy_evt) begin
      s_next.irq_acc = 1'b1;
    end
    if (aux_drdy_evt) begin
      s_next.irq_aux = 1'b1;
    end
    if ((wtm_level != '0) && (s_reg.level < wtm_level) && (lvl_new >= wtm_level)) begin
      s_next.irq_wtm = 1'b1;
    end
    if ((s_reg.level != LEVEL_FULL) && (lvl_new == LEVEL_FULL)) begin
      s_next.irq_full = 1'b1;
    end

    // soft reset flushes the queue and raises the power-up flag
    if (soft_rst) begin
      s_next.pwr_flag = 1'b1;
      s_next.wptr = '0;
      s_next.rptr = '0;
      s_next.level = '0;
      s_next.skid_cnt = 2'd0;
      s_next.in_ready = 1'b1;
      s_next.irq_wtm = 1'b0;
      s_next.irq_full = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.pwr_flag <= PWR_EVENT_RESET[PWR_FLAG_BIT];
      s_reg.in_ready <= 1'b1;
      s_reg.rdata <= READ_ZERO;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data = s_reg.rdata;
  assign rd_valid = s_reg.rvalid;
  assign q_in_ready = s_reg.in_ready;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  property p_time_high;
    rd_go && (reg_addr == ADDR_TIME_HIGH) |=> rd_valid && (rd_data == $past(s_reg.time_cnt[23:16]));
  endproperty
  a_time_high: assert property (p_time_high) else $error("time high byte mismatch");

  property p_time_low;
    rd_go && (reg_addr == ADDR_TIME_LOW) |=> rd_data == $past(s_reg.time_cnt[7:0]);
  endproperty
  a_time_low: assert property (p_time_low) else $error("time low byte mismatch");

  property p_time_step;
    $changed(s_reg.time_cnt) |=> $stable(s_reg.time_cnt) [*8];
  endproperty
  a_time_step: assert property (p_time_step) else $error("time counter steps too fast");

  property p_pwr_set;
    soft_rst |=> s_reg.pwr_flag ##1 (rd_data[PWR_FLAG_BIT] || !$past(rd_go && reg_addr == ADDR_PWR_EVENT));
  endproperty
  a_pwr_set: assert property (p_pwr_set) else $error("power-up flag not set");

  property p_pwr_clear;
    rd_go && (reg_addr == ADDR_PWR_EVENT) && !soft_rst && s_reg.pwr_flag |=> !s_reg.pwr_flag && rd_data == 8'h01;
  endproperty
  a_pwr_clear: assert property (p_pwr_clear) else $error("power-up flag read/clear wrong");

  property p_irq_clear;
    rd_go && (reg_addr == ADDR_IRQ_FLAGS) && !acc_drdy_evt && !aux_drdy_evt && !drain && !pop
      |=> !s_reg.irq_acc && !s_reg.irq_aux && (rd_data[6] == 1'b0) && (rd_data[4:2] == 3'b000);
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt flags not cleared");

  property p_drdy_set;
    acc_drdy_evt |=> s_reg.irq_acc;
  endproperty
  a_drdy_set: assert property (p_drdy_set) else $error("data ready event lost");

  property p_full_set;
    !soft_rst && (s_reg.level != LEVEL_FULL) ##1 (s_reg.level == LEVEL_FULL) |-> s_reg.irq_full;
  endproperty
  a_full_set: assert property (p_full_set) else $error("full event missing");

  property p_level_high;
    rd_go && (reg_addr == ADDR_LEVEL_HIGH) |=> (rd_data[7:6] == 2'b00) && (rd_data[5:0] == $past(s_reg.level[13:8]));
  endproperty
  a_level_high: assert property (p_level_high) else $error("level high byte wrong");

  property p_pop_level;
    pop && !drain && !soft_rst |=> s_reg.level == $past(s_reg.level) - LEVEL_W'(1);
  endproperty
  a_pop_level: assert property (p_pop_level) else $error("queue read did not consume a byte");

  property p_remap;
    (remap_src_x == remap_src_y) ##1 (rd_go && (reg_addr == ADDR_HEALTH)) |=> rd_data[HEALTH_REMAP_BIT];
  endproperty
  a_remap: assert property (p_remap) else $error("remap fault not shown");

  property p_write_ignored;
    wr_en && !soft_rst && !acc_drdy_evt |=> !rd_valid && (s_reg.pwr_flag == $past(s_reg.pwr_flag));
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("write changed state");

  property p_time_mid;
    rd_go && (reg_addr == ADDR_TIME_MID) |=> rd_data == $past(s_reg.time_cnt[15:8]);
  endproperty
  a_time_mid: assert property (p_time_mid) else $error("time middle byte mismatch");

  property p_aux_set;
    aux_drdy_evt |=> s_reg.irq_aux;
  endproperty
  a_aux_set: assert property (p_aux_set) else $error("aux data ready event lost");

  property p_irq_map;
    rd_go && (reg_addr == ADDR_IRQ_FLAGS) |=> rd_data == {$past(s_reg.irq_acc), 1'b0, $past(s_reg.irq_aux), 3'b000,
      $past(s_reg.irq_wtm), $past(s_reg.irq_full)};
  endproperty
  a_irq_map: assert property (p_irq_map) else $error("interrupt flag layout wrong");

  property p_wtm_set;
    !soft_rst && (wtm_level != '0) && (s_reg.level < wtm_level)
      ##1 (s_reg.level >= $past(wtm_level)) |-> s_reg.irq_wtm;
  endproperty
  a_wtm_set: assert property (p_wtm_set) else $error("watermark event missing");

  property p_temp;
    rd_go && (reg_addr == ADDR_TEMP) |=> rd_data == $past(temp_raw);
  endproperty
  a_temp: assert property (p_temp) else $error("temperature read wrong");

  property p_level_low;
    rd_go && (reg_addr == ADDR_LEVEL_LOW) |=> rd_data == $past(s_reg.level[7:0]);
  endproperty
  a_level_low: assert property (p_level_low) else $error("level low byte wrong");

  property p_empty_read;
    rd_go && (reg_addr == ADDR_QUEUE_PORT) && (s_reg.level == '0) |=> rd_data == QUEUE_EMPTY_READ;
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("empty queue read not zero");

  property p_msg;
    rd_go && (reg_addr == ADDR_HEALTH) && $past(rst_b) |=> rd_data[MSG_W-1:0] == $past(init_msg, 2);
  endproperty
  a_msg: assert property (p_msg) else $error("message code wrong");

  property p_low_rate;
    rd_go && (reg_addr == ADDR_HEALTH) && $past(rst_b)
      |=> rd_data[HEALTH_LOW_RATE_BIT] == $past(rate50_features_on && (acc_rate_code < RATE_50HZ_CODE), 2);
  endproperty
  a_low_rate: assert property (p_low_rate) else $error("low rate fault wrong");

  property p_tap_rate;
    rd_go && (reg_addr == ADDR_HEALTH) && $past(rst_b)
      |=> rd_data[HEALTH_TAP_RATE_BIT] == $past(tap_on && (acc_rate_code < TAP_MIN_RATE_CODE), 2);
  endproperty
  a_tap_rate: assert property (p_tap_rate) else $error("tap rate fault wrong");

  property p_no_overrun;
    push |-> (s_reg.skid_cnt != 2'd2);
  endproperty
  a_no_overrun: assert property (p_no_overrun) else $error("byte taken into a full buffer");

  property p_level_bound;
    s_reg.level <= LEVEL_FULL;
  endproperty
  a_level_bound: assert property (p_level_bound) else $error("level beyond depth");

  c_burst: cover property (pop ##1 pop ##1 pop);
  c_full: cover property (s_reg.level == LEVEL_FULL);
  c_stall: cover property (q_in_valid && !q_in_ready);
  c_por_read: cover property (rd_go && reg_addr == ADDR_PWR_EVENT && s_reg.pwr_flag);
  c_wtm: cover property (s_reg.irq_wtm);

endmodule : motion_sensor_status_regs
`default_nettype wire

// File: tb/queue_source.sv
`timescale 1ns/100ps
`default_nettype none
module queue_source (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // control from the bench
  input wire logic [7:0] limit,
  output logic [7:0] sent,
  // byte stream into the block
  input wire logic q_in_ready,
  output logic q_in_valid,
  output logic [7:0] q_in_data
);
  // offer is held until taken, bytes numbered from 0x10
  assign q_in_valid = rst_b && (sent < limit);
  // idle line shows the inverse so a stale byte never looks fresh
  assign q_in_data = q_in_valid ? 8'h10 + sent : ~(8'h10 + sent);
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sent <= 8'h00;
    end else if (q_in_valid && q_in_ready) begin
      sent <= sent + 8'h01;
    end
  end
endmodule : queue_source
`default_nettype wire

// File: tb/motion_sensor_status_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
module motion_sensor_status_regs_test;
  import motion_status_pkg::*;
  logic clk_sys, rst_b, soft_rst, rd_en, wr_en, rd_valid, acc_drdy_evt, aux_drdy_evt;
  logic q_in_valid, q_in_ready, rate50_features_on, tap_on;
  logic [7:0] reg_addr, rd_data, temp_raw, q_in_data, sent, limit;
  logic [13:0] wtm_level;
  logic [4:0] init_msg;
  logic [1:0] remap_src_x, remap_src_y, remap_src_z;
  logic [3:0] acc_rate_code;
  int n_mismatch, checked, i;
  logic [7:0] zeros [13] = '{8'h1A, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2A, 8'hFF};
  logic [3:0] rt [4] = '{4'h6, 4'h7, 4'h7, 4'h9};
  logic tp [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic [7:0] ex [4] = '{8'h44, 8'h04, 8'h84, 8'h04};

  motion_sensor_status_regs #(.DEPTH(8)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .soft_rst(soft_rst),
    .rd_en(rd_en), .wr_en(wr_en), .reg_addr(reg_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .acc_drdy_evt(acc_drdy_evt), .aux_drdy_evt(aux_drdy_evt), .temp_raw(temp_raw), .wtm_level(wtm_level),
    .init_msg(init_msg), .remap_src_x(remap_src_x), .remap_src_y(remap_src_y), .remap_src_z(remap_src_z),
    .acc_rate_code(acc_rate_code), .rate50_features_on(rate50_features_on), .tap_on(tap_on),
    .q_in_valid(q_in_valid), .q_in_data(q_in_data), .q_in_ready(q_in_ready));
  queue_source src_u (.clk_sys(clk_sys), .rst_b(rst_b), .limit(limit), .sent(sent),
    .q_in_ready(q_in_ready), .q_in_valid(q_in_valid), .q_in_data(q_in_data));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one read; right at an edge the answer seen is the one that stood at that edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    int n;
    @(posedge clk_sys);
    rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rd_valid !== 1'b1 && n < 4);
    if (rd_valid !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end else begin
      chk($sformatf("register %h", a), rd_data, exp);
    end
  endtask : rd

  task automatic wr(input logic [7:0] a);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  initial begin
    {rst_b, soft_rst, rd_en, wr_en, acc_drdy_evt, aux_drdy_evt, rate50_features_on, tap_on} = '0;
    {reg_addr, temp_raw, limit, init_msg} = '0;
    wtm_level = 14'h0004;
    {remap_src_x, remap_src_y, remap_src_z} = 6'b00_01_10;
    acc_rate_code = 4'h8;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (zeros[k]) rd(zeros[k], 8'h00);
    rd(8'h1B, 8'h01);
    rd(8'h1B, 8'h00);
    // about 1150 cycles after release: one tick of 39.0625 us has passed, not two
    repeat (1100) @(posedge clk_sys);
    rd(8'h18, 8'h01);
    rd(8'h19, 8'h00);
    @(posedge clk_sys);
    acc_drdy_evt <= 1'b1;
    aux_drdy_evt <= 1'b1;
    @(posedge clk_sys);
    acc_drdy_evt <= 1'b0;
    aux_drdy_evt <= 1'b0;
    wr(8'h1D);
    wr(8'h1B);
    rd(8'h1D, 8'hA0);
    rd(8'h1D, 8'h00);
    rd(8'h1B, 8'h00);
    temp_raw <= 8'hE7;
    rd(8'h22, 8'hE7);
    for (i = 0; i < 5; i++) begin
      init_msg <= i[4:0];
      rd(8'h2A, i[7:0]);
    end
    remap_src_y <= 2'b00;
    rd(8'h2A, 8'h24);
    remap_src_y <= 2'b01;
    rate50_features_on <= 1'b1;
    for (i = 0; i < 4; i++) begin
      acc_rate_code <= rt[i];
      tap_on <= tp[i];
      rd(8'h2A, ex[i]);
    end
    // fill past the memory until the skid refuses
    limit <= 8'd10;
    for (i = 0; i < 60 && sent != 8'd10; i++) @(posedge clk_sys);
    repeat (5) @(posedge clk_sys);
    chk("queue ready", {7'b0, q_in_ready}, 8'h00);
    chk("bytes taken", sent, 8'd10);
    rd(8'h24, 8'h08);
    rd(8'h25, 8'h00);
    rd(8'h1D, 8'h03);
    for (i = 0; i < 10; i++) rd(8'h26, 8'h10 + i[7:0]);
    rd(8'h24, 8'h00);
    rd(8'h26, 8'h00);
    @(posedge clk_sys);
    soft_rst <= 1'b1;
    @(posedge clk_sys);
    soft_rst <= 1'b0;
    rd(8'h1B, 8'h01);
    rd(8'h1D, 8'h00);
    end_sim();
  end
endmodule : motion_sensor_status_regs_test
`default_nettype wire
